// File: common/cmte_defs.vh
// Constants of the channel message-type engine: sizes, register map, fields.
// Assumes a 12-bit APB byte address and a 128-byte mailbox.
`ifndef CMTE_DEFS_VH
`define CMTE_DEFS_VH

`define CMTE_NCH          14
`define CMTE_CHW          4
`define CMTE_IDW          12
`define CMTE_LENW         5
`define CMTE_MBW          7

// Per-channel register set, one word each, stride 0x20
`define CMTE_CH_LIMIT     12'h1C0
`define CMTE_CH_SEL_HI    4
`define CMTE_CH_SEL_LO    2
`define CMTE_CH_IDX_HI    8
`define CMTE_CH_IDX_LO    5
`define CMTE_REG_ID       3'h0
`define CMTE_REG_MASK     3'h1
`define CMTE_REG_CMD      3'h2
`define CMTE_REG_LEN      3'h3
`define CMTE_REG_PTR      3'h4

// Mailbox window 0x400..0x5FC, one byte per word
`define CMTE_MB_TAG_HI    11
`define CMTE_MB_TAG_LO    9
`define CMTE_MB_TAG       3'h2
`define CMTE_MB_IDX_HI    8
`define CMTE_MB_IDX_LO    2

// Command register fields
`define CMTE_CMD_TYPE     1
`define CMTE_CMD_RREQ     0
// Length and status register fields
`define CMTE_LEN_HI       7
`define CMTE_LEN_LO       3
`define CMTE_ST_TX        1
`define CMTE_ST_RX        0

// Message-type codes {request_type_bit, reply_request_bit}
`define CMTE_T_TRANSMIT   2'h0
`define CMTE_T_RECEIVE    2'h1
`define CMTE_T_REPLY      2'h2
`define CMTE_T_RREQ       2'h3

// Reception kinds
`define CMTE_K_DATA       2'h0
`define CMTE_K_DETECT     2'h1
`define CMTE_K_IFR        2'h2

`define CMTE_CRC_BYTES    6'h02
`define CMTE_TOT_MAX      6'h3F

`endif

// File: hw/cmte_engine.v
// Channel message-type engine: channel registers, type decode, mailbox DMA.
// Assumes a line layer on the same clock that frames, retries and codes the bus.
`timescale 1ns/100ps
`include "cmte_defs.vh"

// Function
// - data stored from pointer plus one, ascending
// - CRC bytes stored when room allows
// - field ends at reserved length or EOD
// - mailbox address wraps 0x7F to 0x00
// - transmit message sets transmitted flag only
// - transmit repeats until success or retries exceeded
// - receive message never sends, sets received
// - receive accepts first masked identifier match
// - length byte first, data after it
// - matched identifier register takes received identifier
// - reply request unanswered sets transmitted only
// - waiting state listens, never resends
// - in-frame reply sets both flags together
// - listen-only reply request sets received
// - immediate reply supplies buffer, sets both
// - deferred reply sends at once, sets transmitted
// - detection accepts reply request, sets received
// - both flags set means inactive
// - illegal reply request sends, stores nothing
// - engine only sets flags, host writes either value
// - mask one compares bit, zero ignores
// - lowest-numbered channel served first
module cmte_engine (
   input  wire                   i_clk,
   input  wire                   i_reset,
   input  wire                   i_psel,
   input  wire                   i_penable,
   input  wire                   i_pwrite,
   input  wire [11:0]            i_paddr,
   input  wire [31:0]            i_pwdata,
   output reg  [31:0]            o_prdata,
   output reg                    o_pready,
   output reg                    o_pslverr,
   input  wire                   i_rx_hdr,
   input  wire [`CMTE_IDW-1:0]   i_rx_id,
   input  wire                   i_rx_request_type,
   input  wire                   i_rx_reply_request,
   input  wire                   i_rx_rak,
   input  wire                   i_rx_byte_valid,
   input  wire [7:0]             i_rx_byte,
   input  wire                   i_rx_eod,
   input  wire                   i_rx_ok,
   input  wire                   i_rx_err,
   output reg                    o_tx_req,
   output reg  [`CMTE_CHW-1:0]   o_tx_chan,
   output reg  [`CMTE_IDW-1:0]   o_tx_id,
   output reg                    o_tx_request_type,
   output reg                    o_tx_reply_request,
   output reg  [`CMTE_LENW-1:0]  o_tx_len,
   input  wire                   i_tx_start,
   input  wire                   i_tx_done,
   input  wire                   i_tx_ok,
   input  wire                   i_tx_final,
   input  wire                   i_tx_ifr,
   output reg                    o_ifr_ready,
   output reg  [`CMTE_LENW-1:0]  o_ifr_len,
   input  wire                   i_ifr_done,
   input  wire                   i_ifr_ok,
   input  wire                   i_tx_byte_req,
   output wire [7:0]             o_tx_byte,
   output reg                    o_tx_byte_valid
);

   reg  [`CMTE_IDW-1:0]  ch_id   [0:`CMTE_NCH-1];
   reg  [`CMTE_IDW-1:0]  ch_mask [0:`CMTE_NCH-1];
   reg  [1:0]            ch_cmd  [0:`CMTE_NCH-1];
   reg  [`CMTE_LENW-1:0] ch_len  [0:`CMTE_NCH-1];
   reg                   ch_txf  [0:`CMTE_NCH-1];
   reg                   ch_rxf  [0:`CMTE_NCH-1];
   reg  [`CMTE_MBW-1:0]  ch_ptr  [0:`CMTE_NCH-1];

   wire [`CMTE_NCH-1:0]  tx_rdy;
   wire [`CMTE_NCH-1:0]  hit_data;
   wire [`CMTE_NCH-1:0]  hit_rreq;

   reg                   tx_busy;
   reg  [`CMTE_CHW-1:0]  tx_chan;
   reg                   rx_active;
   reg                   rx_eod;
   reg  [1:0]            rx_kind;
   reg  [`CMTE_CHW-1:0]  rx_chan;
   reg  [`CMTE_IDW-1:0]  rx_id;
   reg                   rx_request_type;
   reg                   rx_reply_request;
   reg  [`CMTE_LENW-1:0] rx_cnt;
   reg  [5:0]            rx_tot;
   reg                   ifr_active;
   reg  [`CMTE_CHW-1:0]  act_chan;
   reg  [`CMTE_LENW-1:0] act_idx;
   reg                   fetch_pend;
   reg                   stat_pend;
   reg  [`CMTE_CHW-1:0]  stat_chan;
   reg  [7:0]            stat_byte;
   reg                   apb_rd_wait;

   // Lowest set bit wins; shared by transmit and receive selection
   function [`CMTE_CHW:0] pick_low;
      input [`CMTE_NCH-1:0] v;
      integer k;
      begin
         pick_low = {1'b0, {`CMTE_CHW{1'b0}}};
         for (k = `CMTE_NCH-1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               pick_low = {1'b1, k[`CMTE_CHW-1:0]};
            end
         end
      end
   endfunction

   // Data slots behind the status byte
   function [`CMTE_LENW-1:0] room_of;
      input [`CMTE_LENW-1:0] len;
      begin
         room_of = (len == {`CMTE_LENW{1'b0}}) ? {`CMTE_LENW{1'b0}} : len - 1'b1;
      end
   endfunction

   // Message-type decode per channel
   genvar g;
   generate
      for (g = 0; g < `CMTE_NCH; g = g + 1) begin : g_type
         wire idm = (((i_rx_id ^ ch_id[g]) & ch_mask[g]) == {`CMTE_IDW{1'b0}});
         // Both flags set never qualifies below
         assign tx_rdy[g] = !ch_txf[g] &&
                            (ch_cmd[g] == `CMTE_T_TRANSMIT ||
                             ch_cmd[g] == `CMTE_T_RREQ ||
                             (ch_cmd[g] == `CMTE_T_REPLY && ch_rxf[g]));
         assign hit_data[g] = idm && !i_rx_reply_request && !ch_rxf[g] &&
                              (ch_cmd[g] == `CMTE_T_RECEIVE ||
                               (ch_cmd[g] == `CMTE_T_RREQ && i_rx_request_type));
         assign hit_rreq[g] = idm && i_rx_reply_request && !ch_rxf[g] &&
                              ch_cmd[g] == `CMTE_T_REPLY;
      end
   endgenerate

   wire [`CMTE_CHW:0]    tx_pick  = pick_low(tx_rdy);
   wire [`CMTE_CHW:0]    dat_pick = pick_low(hit_data);
   wire [`CMTE_CHW:0]    rq_pick  = pick_low(hit_rreq);

   // APB decode
   wire                  acc      = i_psel && i_penable;
   wire [2:0]            sel      = i_paddr[`CMTE_CH_SEL_HI:`CMTE_CH_SEL_LO];
   wire [`CMTE_CHW-1:0]  cidx     = i_paddr[`CMTE_CH_IDX_HI:`CMTE_CH_IDX_LO];
   wire                  reg_hit  = (i_paddr < `CMTE_CH_LIMIT) && (i_paddr[1:0] == 2'h0) &&
                                    (sel <= `CMTE_REG_PTR);
   wire                  mb_hit   = (i_paddr[`CMTE_MB_TAG_HI:`CMTE_MB_TAG_LO] == `CMTE_MB_TAG) &&
                                    (i_paddr[1:0] == 2'h0);
   wire                  reg_wr   = acc && i_pwrite && reg_hit;

   // Mailbox port: reception first, status byte, byte fetch, then software
   wire [`CMTE_LENW-1:0] rx_room  = room_of(ch_len[rx_chan]);
   wire                  rx_wr    = i_rx_byte_valid && rx_active && !rx_eod &&
                                    (rx_cnt < rx_room);
   wire [`CMTE_MBW-1:0]  rx_addr  = ch_ptr[rx_chan] + {{(`CMTE_MBW-1){1'b0}}, 1'b1} +
                                    {2'b00, rx_cnt};
   wire [`CMTE_MBW-1:0]  fe_addr  = ch_ptr[act_chan] + {{(`CMTE_MBW-1){1'b0}}, 1'b1} +
                                    {2'b00, act_idx};
   wire                  fe_go    = fetch_pend && !rx_wr && !stat_pend;
   wire                  apb_go   = acc && mb_hit && !rx_wr && !stat_pend && !fetch_pend &&
                                    !apb_rd_wait;
   wire [5:0]            tot_data = (rx_eod && rx_tot >= `CMTE_CRC_BYTES) ?
                                    rx_tot - `CMTE_CRC_BYTES : rx_tot;
   wire [7:0]            rx_stat  = {i_rx_rak, rx_request_type, rx_reply_request, tot_data[`CMTE_LENW-1:0]};

   reg                   mem_we;
   reg  [`CMTE_MBW-1:0]  mem_addr;
   reg  [7:0]            mem_wdata;
   wire [7:0]            mem_rdata;

   always @* begin
      mem_we    = 1'b0;
      mem_addr  = i_paddr[`CMTE_MB_IDX_HI:`CMTE_MB_IDX_LO];
      mem_wdata = i_pwdata[7:0];
      if (rx_wr) begin
         mem_we    = 1'b1;
         mem_addr  = rx_addr;
         mem_wdata = i_rx_byte;
      end else if (stat_pend) begin
         mem_we    = 1'b1;
         mem_addr  = ch_ptr[stat_chan];
         mem_wdata = stat_byte;
      end else if (fetch_pend) begin
         mem_addr  = fe_addr;
      end else if (apb_go) begin
         mem_we    = i_pwrite;
      end
   end

   cmte_mem u_mem (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_we    (mem_we),
      .i_addr  (mem_addr),
      .i_wdata (mem_wdata),
      .o_rdata (mem_rdata)
   );

   assign o_tx_byte = mem_rdata;

   // Completion events
   wire rx_done  = i_rx_ok && rx_active && !tx_busy && rx_kind != `CMTE_K_IFR;
   wire tx_end   = i_tx_done && tx_busy && (i_tx_ok || i_tx_final);
   wire tx_store = tx_end && i_tx_ok && i_tx_ifr && rx_active;
   wire ifr_end  = i_ifr_done && ifr_active && i_ifr_ok;

   // Channel registers; engine flag sets come last so they beat a host clear
   integer c;
   always @(posedge i_clk) begin
      if (i_reset) begin
         for (c = 0; c < `CMTE_NCH; c = c + 1) begin
            ch_id[c]   <= {`CMTE_IDW{1'b0}};
            ch_mask[c] <= {`CMTE_IDW{1'b0}};
            ch_cmd[c]  <= `CMTE_T_TRANSMIT;
            ch_len[c]  <= {`CMTE_LENW{1'b0}};
            ch_txf[c]  <= 1'b1;
            ch_rxf[c]  <= 1'b1;
            ch_ptr[c]  <= {`CMTE_MBW{1'b0}};
         end
      end else begin
         if (reg_wr) begin
            case (sel)
               `CMTE_REG_ID:   ch_id[cidx]   <= i_pwdata[`CMTE_IDW-1:0];
               `CMTE_REG_MASK: ch_mask[cidx] <= i_pwdata[`CMTE_IDW-1:0];
               `CMTE_REG_CMD:  ch_cmd[cidx]  <= i_pwdata[`CMTE_CMD_TYPE:`CMTE_CMD_RREQ];
               `CMTE_REG_LEN: begin
                  ch_len[cidx] <= i_pwdata[`CMTE_LEN_HI:`CMTE_LEN_LO];
                  ch_txf[cidx] <= i_pwdata[`CMTE_ST_TX];
                  ch_rxf[cidx] <= i_pwdata[`CMTE_ST_RX];
               end
               `CMTE_REG_PTR:  ch_ptr[cidx]  <= i_pwdata[`CMTE_MBW-1:0];
               default: ;
            endcase
         end
         if (rx_done) begin
            ch_rxf[rx_chan] <= 1'b1;
            ch_id[rx_chan]  <= rx_id;
         end
         if (tx_end) begin
            ch_txf[tx_chan] <= 1'b1;
            if (tx_store) begin
               ch_rxf[tx_chan] <= 1'b1;
            end
         end
         if (ifr_end) begin
            ch_txf[act_chan] <= 1'b1;
            ch_rxf[act_chan] <= 1'b1;
         end
      end
   end

   // Reception and transmission sequencing
   always @(posedge i_clk) begin
      if (i_reset) begin
         tx_busy     <= 1'b0;
         tx_chan     <= {`CMTE_CHW{1'b0}};
         rx_active   <= 1'b0;
         rx_eod      <= 1'b0;
         rx_kind     <= `CMTE_K_DATA;
         rx_chan     <= {`CMTE_CHW{1'b0}};
         rx_id       <= {`CMTE_IDW{1'b0}};
         rx_request_type  <= 1'b0;
         rx_reply_request <= 1'b0;
         rx_cnt      <= {`CMTE_LENW{1'b0}};
         rx_tot      <= 6'h00;
         ifr_active  <= 1'b0;
         act_chan    <= {`CMTE_CHW{1'b0}};
         act_idx     <= {`CMTE_LENW{1'b0}};
         fetch_pend  <= 1'b0;
         stat_pend   <= 1'b0;
         stat_chan   <= {`CMTE_CHW{1'b0}};
         stat_byte   <= 8'h00;
         o_ifr_ready <= 1'b0;
         o_ifr_len   <= {`CMTE_LENW{1'b0}};
         o_tx_byte_valid <= 1'b0;
      end else begin
         o_tx_byte_valid <= fe_go;
         if (i_tx_byte_req) begin
            fetch_pend <= 1'b1;
         end else if (fe_go) begin
            fetch_pend <= 1'b0;
         end
         if (fe_go) begin
            act_idx <= act_idx + 1'b1;
         end
         if (stat_pend && !rx_wr) begin
            stat_pend <= 1'b0;
         end
         if (rx_wr) begin
            rx_cnt <= rx_cnt + 1'b1;
         end
         if (i_rx_byte_valid && rx_active && !rx_eod && rx_tot != `CMTE_TOT_MAX) begin
            rx_tot <= rx_tot + 1'b1;
         end
         if (i_rx_eod && rx_active) begin
            rx_eod <= 1'b1;
         end
         // Header of a frame from another node
         if (i_rx_hdr && !tx_busy) begin
            rx_id  <= i_rx_id;
            rx_request_type  <= i_rx_request_type;
            rx_reply_request <= i_rx_reply_request;
            rx_eod <= 1'b0;
            rx_cnt <= {`CMTE_LENW{1'b0}};
            rx_tot <= 6'h00;
            if (dat_pick[`CMTE_CHW]) begin
               rx_active <= 1'b1;
               rx_kind   <= `CMTE_K_DATA;
               rx_chan   <= dat_pick[`CMTE_CHW-1:0];
            end else if (rq_pick[`CMTE_CHW]) begin
               rx_active <= 1'b1;
               rx_chan   <= rq_pick[`CMTE_CHW-1:0];
               if (ch_txf[rq_pick[`CMTE_CHW-1:0]]) begin
                  rx_kind <= `CMTE_K_DETECT;
               end else begin
                  rx_kind     <= `CMTE_K_IFR;
                  ifr_active  <= 1'b1;
                  o_ifr_ready <= 1'b1;
                  o_ifr_len   <= room_of(ch_len[rq_pick[`CMTE_CHW-1:0]]);
                  act_chan    <= rq_pick[`CMTE_CHW-1:0];
                  act_idx     <= {`CMTE_LENW{1'b0}};
               end
            end else begin
               rx_active <= 1'b0;
            end
         end
         if (rx_done || (i_rx_err && !tx_busy)) begin
            rx_active <= 1'b0;
         end
         if (rx_done && rx_kind == `CMTE_K_DATA) begin
            stat_pend <= 1'b1;
            stat_chan <= rx_chan;
            stat_byte <= rx_stat;
         end
         if (i_ifr_done && ifr_active) begin
            ifr_active  <= 1'b0;
            o_ifr_ready <= 1'b0;
            rx_active   <= 1'b0;
         end
         // Own frame; an answering in-frame reply lands in the same buffer
         if (i_tx_start && o_tx_req && !tx_busy) begin
            tx_busy  <= 1'b1;
            tx_chan  <= o_tx_chan;
            act_chan <= o_tx_chan;
            act_idx  <= {`CMTE_LENW{1'b0}};
            rx_chan  <= o_tx_chan;
            rx_kind  <= `CMTE_K_DATA;
            rx_request_type  <= o_tx_request_type;
            rx_reply_request <= o_tx_reply_request;
            rx_eod   <= 1'b0;
            rx_cnt   <= {`CMTE_LENW{1'b0}};
            rx_tot   <= 6'h00;
            // Occupied buffer takes nothing back
            rx_active <= (ch_cmd[o_tx_chan] == `CMTE_T_RREQ) && !ch_rxf[o_tx_chan];
         end
         if (i_tx_done && tx_busy) begin
            tx_busy   <= 1'b0;
            rx_active <= 1'b0;
         end
         if (tx_store) begin
            stat_pend <= 1'b1;
            stat_chan <= tx_chan;
            stat_byte <= rx_stat;
         end
      end
   end

   // Candidate frame, held steady while a transmission runs
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_tx_req           <= 1'b0;
         o_tx_chan          <= {`CMTE_CHW{1'b0}};
         o_tx_id            <= {`CMTE_IDW{1'b0}};
         o_tx_request_type  <= 1'b0;
         o_tx_reply_request <= 1'b0;
         o_tx_len           <= {`CMTE_LENW{1'b0}};
      end else if (tx_busy || (i_tx_start && o_tx_req)) begin
         o_tx_req <= 1'b0;
      end else begin
         o_tx_req           <= tx_pick[`CMTE_CHW];
         o_tx_chan          <= tx_pick[`CMTE_CHW-1:0];
         o_tx_id            <= ch_id[tx_pick[`CMTE_CHW-1:0]];
         o_tx_request_type  <= ch_cmd[tx_pick[`CMTE_CHW-1:0]][`CMTE_CMD_TYPE];
         o_tx_reply_request <= ch_cmd[tx_pick[`CMTE_CHW-1:0]][`CMTE_CMD_RREQ];
         o_tx_len           <= room_of(ch_len[tx_pick[`CMTE_CHW-1:0]]);
      end
   end

   // APB answer
   always @(posedge i_clk) begin
      if (i_reset) begin
         apb_rd_wait <= 1'b0;
      end else begin
         apb_rd_wait <= apb_go && !i_pwrite;
      end
   end

   always @* begin
      o_prdata  = 32'h00000000;
      o_pslverr = 1'b0;
      o_pready  = 1'b0;
      if (acc) begin
         if (reg_hit) begin
            o_pready = 1'b1;
            case (sel)
               `CMTE_REG_ID:   o_prdata = {20'h00000, ch_id[cidx]};
               `CMTE_REG_MASK: o_prdata = {20'h00000, ch_mask[cidx]};
               `CMTE_REG_CMD:  o_prdata = {30'h00000000, ch_cmd[cidx]};
               `CMTE_REG_LEN:  o_prdata = {24'h000000, ch_len[cidx], 1'b0, ch_txf[cidx], ch_rxf[cidx]};
               `CMTE_REG_PTR:  o_prdata = {25'h0000000, ch_ptr[cidx]};
               default:        o_prdata = 32'h00000000;
            endcase
         end else if (mb_hit) begin
            // Reads wait one cycle for the registered RAM output
            o_pready = i_pwrite ? apb_go : apb_rd_wait;
            o_prdata = {24'h000000, mem_rdata};
         end else begin
            o_pready  = 1'b1;
            o_pslverr = 1'b1;
         end
      end
   end

endmodule // cmte_engine

// File: hw/cmte_mem.v
// Mailbox storage, 128 bytes, one write/read port, registered read data.
// Assumes its user arbitrates the single port.
`timescale 1ns/100ps
`include "cmte_defs.vh"

module cmte_mem (
   input  wire                   i_clk,
   input  wire                   i_reset,
   input  wire                   i_we,
   input  wire [`CMTE_MBW-1:0]   i_addr,
   input  wire [7:0]             i_wdata,
   output reg  [7:0]             o_rdata
);

   // Contents are not reset: pure RAM
   reg [7:0] mem [0:(1<<`CMTE_MBW)-1];

   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= mem[i_addr];
      end
   end

endmodule // cmte_mem

// File: test/cmte_engine_properties.sv
// Port checks of the channel message-type engine.
// Bound to cmte_engine; sees only its ports, one clock.
`timescale 1ns/100ps
module cmte_engine_properties (
   input wire        i_clk,
   input wire        i_reset,
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [11:0] i_paddr,
   input wire        o_pready,
   input wire        o_pslverr,
   input wire        o_tx_req,
   input wire [3:0]  o_tx_chan,
   input wire        o_tx_request_type,
   input wire        o_tx_reply_request,
   input wire        i_tx_start,
   input wire        i_tx_done,
   input wire        i_tx_ok,
   input wire        i_tx_final,
   input wire        i_tx_byte_req,
   input wire        o_tx_byte_valid
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   wire acc = i_psel && i_penable;
   recv_never_sends_a: assert property (o_tx_req |-> !(!o_tx_request_type && o_tx_reply_request))
      else $error("receive type sent");
   retry_again_a: assert property (i_tx_done && !i_tx_ok && !i_tx_final |-> ##[1:4] o_tx_req)
      else $error("no retry");
   req_drop_a: assert property (i_tx_start && o_tx_req |=> !o_tx_req)
      else $error("request held after start");
   req_hold_a: assert property (o_tx_req && !i_tx_start |=> o_tx_req && $stable(o_tx_chan))
      else $error("request changed");
   fetch_answer_a: assert property (i_tx_byte_req |-> ##[2:6] o_tx_byte_valid)
      else $error("no byte");
   reg_no_wait_a: assert property (acc && i_paddr < 12'h1C0 |-> o_pready)
      else $error("channel access waited");
   unmapped_err_a: assert property (acc && i_paddr[11:9] == 3'h1 |-> o_pready && o_pslverr)
      else $error("unmapped not refused");
   mb_read_wait_a: assert property (acc && $rose(i_penable) && !i_pwrite && i_paddr[11:9] == 3'h2 |-> !o_pready)
      else $error("mailbox read too early");
endmodule // cmte_engine_properties

// File: test/cmte_line.sv
// Line-layer model: takes send requests, fetches one byte, ends attempts.
// Fails the first attempt on purpose so the engine must retry.
`timescale 1ns/100ps
module cmte_line (
   input  wire        i_clk,
   input  wire        i_reset,
   input  wire        i_tx_req,
   input  wire [11:0] i_tx_id,
   input  wire        i_tx_byte_valid,
   input  wire [7:0]  i_tx_byte,
   output reg         o_tx_start,
   output reg         o_tx_done,
   output reg         o_tx_ok,
   output reg         o_tx_byte_req,
   output reg  [11:0] o_seen_id,
   output reg  [7:0]  o_seen_byte,
   output reg  [3:0]  o_tries
);
   reg [3:0] st;
   // Gap after each attempt keeps a stale request from being taken
   always @(posedge i_clk) begin
      o_tx_start <= 1'b0;
      o_tx_done <= 1'b0;
      o_tx_byte_req <= 1'b0;
      if (i_reset) begin
         st <= 4'h0;
         o_tries <= 4'h0;
         o_tx_ok <= 1'b0;
      end else if (st == 4'h0) begin
         if (i_tx_req) begin
            o_tx_start <= 1'b1;
            o_seen_id <= i_tx_id;
            st <= 4'h1;
         end
      end else begin
         st <= st + 4'h1;
         o_tx_byte_req <= (st == 4'h2);
         if (i_tx_byte_valid)
            o_seen_byte <= i_tx_byte;
         if (st == 4'h9) begin
            o_tx_done <= 1'b1;
            o_tx_ok <= o_tries[0];
            o_tries <= o_tries + 4'h1;
         end
      end
   end
endmodule // cmte_line

// File: test/test_channel_message_type_engine.sv
// Bench of the message-type engine: APB tasks, frames in, two sends.
// Assumes cmte_line answers sends; in-frame replies are not exercised.
`timescale 1ns/100ps
bind cmte_engine cmte_engine_properties i_cmte_engine_properties (.*);
module test_channel_message_type_engine;
   logic        i_clk = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000, i_rx_id = 12'h000, b;
   logic [31:0] i_pwdata = 32'h0, rd;
   logic        i_rx_hdr = 1'b0, i_rx_request_type = 1'b0, i_rx_reply_request = 1'b0, i_rx_rak = 1'b0, er;
   logic        i_rx_byte_valid = 1'b0, i_rx_eod = 1'b0, i_rx_ok = 1'b0, i_rx_err = 1'b0;
   logic        i_tx_final = 1'b0, i_tx_ifr = 1'b0, i_ifr_done = 1'b0, i_ifr_ok = 1'b0;
   logic [7:0]  i_rx_byte = 8'h00;
   wire         i_tx_start, i_tx_done, i_tx_ok, i_tx_byte_req, o_pready, o_pslverr, o_tx_req;
   wire         o_tx_request_type, o_tx_reply_request, o_ifr_ready, o_tx_byte_valid;
   wire  [31:0] o_prdata;
   wire  [11:0] o_tx_id, seen_id;
   wire  [7:0]  o_tx_byte, seen_byte;
   wire  [4:0]  o_tx_len, o_ifr_len;
   wire  [3:0]  o_tx_chan, tries;
   integer      fails = 0, compares = 0, c;
   always #4 i_clk = ~i_clk;
   cmte_engine i_cmte_engine (.*);
   cmte_line i_cmte_line (.i_clk(i_clk), .i_reset(i_reset), .i_tx_req(o_tx_req), .i_tx_id(o_tx_id),
      .i_tx_byte_valid(o_tx_byte_valid), .i_tx_byte(o_tx_byte), .o_tx_start(i_tx_start), .o_tx_done(i_tx_done),
      .o_tx_ok(i_tx_ok), .o_tx_byte_req(i_tx_byte_req), .o_seen_id(seen_id), .o_seen_byte(seen_byte), .o_tries(tries));
   task summarize;
      begin
         if (fails == 0 && compares > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer k;
      begin
         @(posedge i_clk);
         i_psel <= 1'b1;
         i_pwrite <= w;
         i_paddr <= a;
         i_pwdata <= d;
         @(posedge i_clk);
         i_penable <= 1'b1;
         k = 0;
         // Read before this edge's updates land
         @(posedge i_clk);
         while (o_pready !== 1'b1 && k < 40) begin
            k = k + 1;
            @(posedge i_clk);
         end
         if (o_pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            summarize;
         end
         rd = o_prdata;
         er = o_pslverr;
         i_psel <= 1'b0;
         i_penable <= 1'b0;
      end
   endtask
   task poll(input logic [11:0] a, input logic [31:0] e);
      integer n;
      begin
         n = 0;
         rd = ~e;
         while (rd !== e && n < 100) begin
            apb(1'b0, a, 32'h0);
            n = n + 1;
         end
         chk(rd, e);
      end
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(rd, e);
      end
   endtask
   // Bytes back to back; CRC bytes arrive as bytes before end of data
   task frame(input logic [11:0] id, input integer nb);
      integer k;
      begin
         @(posedge i_clk);
         i_rx_hdr <= 1'b1;
         i_rx_id <= id;
         i_rx_request_type <= 1'b0;
         i_rx_reply_request <= 1'b0;
         for (k = 0; k < nb; k = k + 1) begin
            @(posedge i_clk);
            i_rx_hdr <= 1'b0;
            i_rx_byte_valid <= 1'b1;
            i_rx_byte <= 8'hA0 + k[7:0];
         end
         @(posedge i_clk);
         i_rx_byte_valid <= 1'b0;
         i_rx_byte <= ~i_rx_byte;
         i_rx_id <= ~id;
         i_rx_request_type <= 1'b1;
         i_rx_reply_request <= 1'b1;
         i_rx_eod <= 1'b1;
         @(posedge i_clk);
         i_rx_eod <= 1'b0;
         i_rx_ok <= 1'b1;
         @(posedge i_clk);
         i_rx_ok <= 1'b0;
      end
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      rdc(12'h00C, 32'h3);
      rdc(12'h200, 32'h0);
      chk(er, 32'h1);
      apb(1'b1, 12'h44C, 32'h55);
      for (c = 1; c < 3; c = c + 1) begin
         b = 12'h020 * c[11:0];
         apb(1'b1, b, 32'h123);
         apb(1'b1, b + 12'h004, 32'hFF0);
         apb(1'b1, b + 12'h008, 32'h1);
         apb(1'b1, b + 12'h010, (c == 1) ? 32'h7E : 32'h10);
         apb(1'b1, b + 12'h00C, (c == 1) ? 32'h30 : 32'h18);
      end
      frame(12'h223, 4);
      rdc(12'h02C, 32'h30);
      frame(12'h12A, 4);
      rdc(12'h02C, 32'h31);
      rdc(12'h04C, 32'h18);
      rdc(12'h020, 32'h12A);
      rdc(12'h5F8, 32'h02);
      rdc(12'h5FC, 32'hA0);
      rdc(12'h400, 32'hA1);
      rdc(12'h404, 32'hA2);
      rdc(12'h408, 32'hA3);
      i_rx_rak <= 1'b1;
      frame(12'h12A, 4);
      rdc(12'h04C, 32'h19);
      rdc(12'h440, 32'h82);
      rdc(12'h448, 32'hA1);
      rdc(12'h44C, 32'h55);
      apb(1'b1, 12'h484, 32'hC3);
      apb(1'b1, 12'h060, 32'h3C5);
      apb(1'b1, 12'h070, 32'h20);
      apb(1'b1, 12'h06C, 32'h10);
      poll(12'h06C, 32'h12);
      chk(tries, 32'h2);
      chk(seen_id, 32'h3C5);
      chk(seen_byte, 32'hC3);
      apb(1'b1, 12'h080, 32'h2B4);
      apb(1'b1, 12'h088, 32'h2);
      apb(1'b1, 12'h08C, 32'h11);
      poll(12'h08C, 32'h13);
      chk(tries, 32'h4);
      chk(seen_id, 32'h2B4);
      chk(seen_byte, 32'hA2);
      summarize;
   end
endmodule // test_channel_message_type_engine
